// ==== rtl/cic_pkg.sv ====
// Shared constants and types for the command and interrupt control block
`default_nettype none
package cic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] CIC_IDX_COMMAND  = 6'h01;
	localparam logic [5:0] CIC_IDX_COM_EN   = 6'h02;
	localparam logic [5:0] CIC_IDX_DIV_EN   = 6'h03;
	localparam logic [5:0] CIC_IDX_COM_REQ  = 6'h04;
	localparam logic [5:0] CIC_IDX_DIV_REQ  = 6'h05;

	// Field positions
	localparam int CIC_RCV_OFF_BIT    = 5;
	localparam int CIC_SLEEP_BIT      = 4;
	localparam int CIC_SET_SELECT_BIT = 7;
	localparam int CIC_INVERT_BIT     = 7;
	localparam int CIC_DRIVER_BIT     = 7;
	localparam int CIC_DIV_CARD_BIT   = 4;
	localparam int CIC_DIV_CRC_BIT    = 2;

	// Reset values and writable masks
	localparam logic [7:0] CIC_COMMAND_RST  = 8'h20;
	localparam logic [7:0] CIC_COM_EN_RST   = 8'h80;
	localparam logic [7:0] CIC_DIV_EN_RST   = 8'h00;
	localparam logic [7:0] CIC_COM_REQ_RST  = 8'h14;
	localparam logic [7:0] CIC_DIV_REQ_RST  = 8'h00;
	localparam logic [7:0] CIC_DIV_EN_MASK  = 8'h94;

	// Command codes
	localparam logic [3:0]  CIC_CMD_IDLE           = 4'h0;
	localparam logic [3:0]  CIC_SOFT_RESET_DEFAULT = 4'hf;
	localparam logic [15:0] CIC_CMD_VALID_DEFAULT  = 16'h80ff;

	// Wake-up time after leaving soft power-down
	localparam int CIC_CLK_PERIOD_NS = 10;
	localparam int CIC_WAKE_TIME_NS  = 1000;
	localparam int CIC_WAKE_CYCLES   = (CIC_WAKE_TIME_NS + CIC_CLK_PERIOD_NS - 1) / CIC_CLK_PERIOD_NS;
	localparam int CIC_WAKE_W        = $clog2(CIC_WAKE_CYCLES + 1);

	typedef enum logic [2:0] {
		CIC_PWR_ON    = 3'b001,
		CIC_PWR_SLEEP = 3'b010,
		CIC_PWR_WAKE  = 3'b100
	} cic_pwr_t;

	// Events from the reader core, all on ref_clk
	typedef struct packed {
		logic       tx_last_bit_sent;
		logic       rx_end_valid;
		logic       fifo_has_data;
		logic       no_error_receive_option;
		logic       fifo_high_alert_status;
		logic       fifo_low_alert_status;
		logic       timer_reached_zero;
		logic       crc_all_processed;
		logic       command_done;
		logic [7:0] error_flag_register;
	} cic_events_t;
endpackage
`default_nettype wire

// ==== rtl/cic_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulse
`default_nettype none
module cic_pin_sync (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Pin side
	input  wire logic pin_in,
	// Synchronised side
	output logic      level_r,
	output logic      edge_r
);
	logic       s1_r;
	logic       s2_r;
	logic       s3_r;
	logic [2:0] fill_r;
	logic       primed_r;
	wire        agree = (s2_r == s3_r);
	wire        moved = agree & (s3_r != level_r);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_r     <= 1'b0;
			s2_r     <= 1'b0;
			s3_r     <= 1'b0;
			fill_r   <= 3'h0;
			primed_r <= 1'b0;
			level_r  <= 1'b0;
			edge_r   <= 1'b0;
		end else begin
			s1_r     <= pin_in;
			s2_r     <= s1_r;
			s3_r     <= s2_r;
			fill_r   <= {fill_r[1:0], 1'b1};
			// No edge until all stages hold real pin samples
			primed_r <= primed_r | (fill_r[2] & agree);
			// First agreement after reset loads the level without an edge
			level_r  <= agree ? s3_r : level_r;
			edge_r   <= moved & primed_r;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/cic_req_bank.sv ====
// Bank of sticky request bits with set-select software access
`default_nettype none
module cic_req_bank #(
	parameter int              WIDTH = 7,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// Hardware events
	input  wire logic [WIDTH-1:0] hw_set,
	// Software write
	input  wire logic             sw_wr,
	input  wire logic             sw_set_sel,
	input  wire logic [WIDTH-1:0] sw_mask,
	// State
	output logic      [WIDTH-1:0] req_r
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			wire sw_set = sw_wr & sw_set_sel & sw_mask[i];
			wire sw_clr = sw_wr & ~sw_set_sel & sw_mask[i];
			// Hardware set wins over a clear in the same cycle
			wire bit_nxt = hw_set[i] | sw_set | (req_r[i] & ~sw_clr);
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					req_r[i] <= RESET[i];
				end else begin
					req_r[i] <= bit_nxt;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== rtl/cic_command_irq.sv ====
// Command register, interrupt enables, requests and interrupt pin driver
//
// Register access over Avalon-MM is this design's own decision.
`default_nettype none
module cic_command_irq
	import cic_pkg::*;
#(
	parameter logic [15:0] CMD_VALID_MASK  = CIC_CMD_VALID_DEFAULT,
	parameter logic [3:0]  SOFT_RESET_CODE = CIC_SOFT_RESET_DEFAULT
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	// Avalon-MM slave
	input  wire logic [7:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	// Reader core events and card input pin
	input  wire cic_events_t  ev,
	input  wire logic         card_serial_input,
	// Command and power control
	output logic      [3:0]   command_code_r,
	output logic              command_start_r,
	output logic              receiver_analog_off_r,
	output logic              soft_sleep_r,
	// Interrupt pin
	output logic              int_pin_out_r,
	output logic              int_pin_oe_n_r
);
	localparam int WAKE_BOUND = CIC_WAKE_CYCLES + 2;

	// Bus decode
	wire       bus_req   = avs_read | avs_write;
	wire       wr_en     = avs_write & ~avs_waitrequest;
	wire       addr_ok   = (avs_address[1:0] == 2'b00);
	wire [5:0] addr_idx  = avs_address[7:2];
	wire       hit_cmd   = addr_ok & (addr_idx == CIC_IDX_COMMAND);
	wire       hit_com_e = addr_ok & (addr_idx == CIC_IDX_COM_EN);
	wire       hit_div_e = addr_ok & (addr_idx == CIC_IDX_DIV_EN);
	wire       hit_com_r = addr_ok & (addr_idx == CIC_IDX_COM_REQ);
	wire       hit_div_r = addr_ok & (addr_idx == CIC_IDX_DIV_REQ);
	wire [7:0] wbyte     = avs_writedata[7:0];
	wire       wr_cmd    = wr_en & hit_cmd;

	// State
	logic [7:0]            com_en_r;
	logic [7:0]            div_en_r;
	logic [6:0]            com_req;
	logic [1:0]            div_req;
	cic_pwr_t              pwr_r;
	cic_pwr_t              pwr_nxt;
	logic [CIC_WAKE_W-1:0] wake_cnt_r;
	logic                  hi_prev_r;
	logic                  lo_prev_r;
	logic [7:0]            err_prev_r;
	logic                  card_edge;

	// Command decode
	wire [3:0] wcode       = wbyte[3:0];
	wire       code_valid  = CMD_VALID_MASK[wcode];
	wire       code_busy   = (command_code_r != CIC_CMD_IDLE);
	wire       reset_cmd   = (command_code_r == SOFT_RESET_CODE);
	wire       reset_in_wr = code_valid & (wcode == SOFT_RESET_CODE);
	wire       sleep_block = reset_cmd | reset_in_wr;
	wire       sleep_req   = wr_cmd & wbyte[CIC_SLEEP_BIT] & ~sleep_block;
	wire       wake_req    = wr_cmd & ~wbyte[CIC_SLEEP_BIT];
	wire       cmd_ends    = ~wr_cmd & ev.command_done & code_busy;
	wire       sleep_read  = (pwr_r != CIC_PWR_ON);

	wire [3:0] code_nxt = wr_cmd ? (code_valid ? wcode : CIC_CMD_IDLE)
	                             : (cmd_ends ? CIC_CMD_IDLE : command_code_r);
	wire       start_nxt = wr_cmd & code_valid & (wcode != CIC_CMD_IDLE);

	// Hardware request events
	// transmit done event
	wire set_tx    = ev.tx_last_bit_sent;
	// receive done, qualified by FIFO data only when no_error_receive_option is set
	wire set_rx    = ev.rx_end_valid & (~ev.no_error_receive_option | ev.fifo_has_data);
	wire set_idle  = (wr_cmd & ~code_valid) | cmd_ends;
	wire set_hi    = ev.fifo_high_alert_status & ~hi_prev_r;
	wire set_lo    = ev.fifo_low_alert_status & ~lo_prev_r;
	wire set_err   = |(ev.error_flag_register & ~err_prev_r);
	wire set_timer = ev.timer_reached_zero;
	wire [6:0] com_set = {set_tx, set_rx, set_idle, set_hi, set_lo, set_err, set_timer};
	// card activity and CRC done events
	wire [1:0] div_set = {card_edge, ev.crc_all_processed};

	// Interrupt status and pin level
	// enabled requests combine
	wire [1:0] div_gate   = {div_en_r[CIC_DIV_CARD_BIT], div_en_r[CIC_DIV_CRC_BIT]};
	wire       irq_status = |(com_req & com_en_r[6:0]) | |(div_req & div_gate);
	wire       int_level  = irq_status ^ com_en_r[CIC_INVERT_BIT];
	wire       push_pull  = div_en_r[CIC_DRIVER_BIT];
	// driver style; open-drain drives only a low
	wire       out_nxt    = push_pull ? int_level : 1'b0;
	wire       oe_n_nxt   = push_pull ? 1'b0 : int_level;

	// Read mux
	wire [7:0] cmd_rd = {2'b00, receiver_analog_off_r, sleep_read, command_code_r};
	wire [7:0] com_rq = {1'b0, com_req};
	wire [7:0] div_rq = {3'b000, div_req[1], 1'b0, div_req[0], 2'b00};
	wire [7:0] rd_mux = hit_cmd   ? cmd_rd :
	                    hit_com_e ? com_en_r :
	                    hit_div_e ? (div_en_r & CIC_DIV_EN_MASK) :
	                    hit_com_r ? com_rq :
	                    hit_div_r ? div_rq : 8'h00;

	// Bus slave: one wait cycle, then the request is taken
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (avs_read & avs_waitrequest) begin
				avs_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Command register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			command_code_r        <= CIC_COMMAND_RST[3:0];
			command_start_r       <= 1'b0;
			receiver_analog_off_r <= CIC_COMMAND_RST[CIC_RCV_OFF_BIT];
		end else begin
			command_code_r  <= code_nxt;
			command_start_r <= start_nxt;
			if (wr_cmd) begin
				receiver_analog_off_r <= wbyte[CIC_RCV_OFF_BIT];
			end
		end
	end

	// Soft power-down sequencing
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			CIC_PWR_ON: begin
				if (sleep_req) begin
					pwr_nxt = CIC_PWR_SLEEP;
				end
			end
			CIC_PWR_SLEEP: begin
				if (wake_req) begin
					pwr_nxt = CIC_PWR_WAKE;
				end
			end
			CIC_PWR_WAKE: begin
				if (sleep_req) begin
					pwr_nxt = CIC_PWR_SLEEP;
				end else if (wake_cnt_r == '0) begin
					pwr_nxt = CIC_PWR_ON;
				end
			end
			default: begin
				pwr_nxt = CIC_PWR_ON;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pwr_r        <= CIC_PWR_ON;
			wake_cnt_r   <= '0;
			soft_sleep_r <= CIC_COMMAND_RST[CIC_SLEEP_BIT];
		end else begin
			pwr_r        <= pwr_nxt;
			soft_sleep_r <= (pwr_nxt == CIC_PWR_SLEEP);
			if (pwr_r != CIC_PWR_WAKE) begin
				wake_cnt_r <= CIC_WAKE_W'(CIC_WAKE_CYCLES - 1);
			end else if (wake_cnt_r != '0) begin
				wake_cnt_r <= wake_cnt_r - 1'b1;
			end
		end
	end

	// Enable registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			com_en_r <= CIC_COM_EN_RST;
			div_en_r <= CIC_DIV_EN_RST;
		end else begin
			if (wr_en & hit_com_e) begin
				com_en_r <= wbyte;
			end
			if (wr_en & hit_div_e) begin
				div_en_r <= wbyte & CIC_DIV_EN_MASK;
			end
		end
	end

	// Edge history for level-style status inputs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hi_prev_r  <= 1'b0;
			lo_prev_r  <= 1'b0;
			err_prev_r <= 8'h00;
		end else begin
			hi_prev_r  <= ev.fifo_high_alert_status;
			lo_prev_r  <= ev.fifo_low_alert_status;
			err_prev_r <= ev.error_flag_register;
		end
	end

	cic_req_bank #(
		.WIDTH (7),
		.RESET (CIC_COM_REQ_RST[6:0])
	) u_com_req (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.hw_set     (com_set),
		.sw_wr      (wr_en & hit_com_r),
		.sw_set_sel (wbyte[CIC_SET_SELECT_BIT]),
		.sw_mask    (wbyte[6:0]),
		.req_r      (com_req)
	);

	// divided requests with their own set-select
	cic_req_bank #(
		.WIDTH (2),
		.RESET ({CIC_DIV_REQ_RST[CIC_DIV_CARD_BIT], CIC_DIV_REQ_RST[CIC_DIV_CRC_BIT]})
	) u_div_req (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.hw_set     (div_set),
		.sw_wr      (wr_en & hit_div_r),
		.sw_set_sel (wbyte[CIC_SET_SELECT_BIT]),
		.sw_mask    ({wbyte[CIC_DIV_CARD_BIT], wbyte[CIC_DIV_CRC_BIT]}),
		.req_r      (div_req)
	);

	cic_pin_sync u_card_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.pin_in  (card_serial_input),
		.level_r (),
		.edge_r  (card_edge)
	);

	// Interrupt pin driver, registered
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			int_pin_out_r  <= 1'b0;
			int_pin_oe_n_r <= 1'b1;
		end else begin
			int_pin_out_r  <= out_nxt;
			int_pin_oe_n_r <= oe_n_nxt;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_rcv_off_write: assert property (
		wr_cmd |=> receiver_analog_off_r == $past(avs_writedata[CIC_RCV_OFF_BIT])
	) else $error("receiver off bit did not follow write");

	a_sleep_entry: assert property (
		(pwr_r == CIC_PWR_ON) && sleep_req |=> soft_sleep_r && sleep_read
	) else $error("sleep not entered");

	// wake reads one then finishes in bounded time
	a_wake_reads_one: assert property (
		(pwr_r == CIC_PWR_SLEEP) && wake_req |=> sleep_read ##[1:WAKE_BOUND] !sleep_read
	) else $error("wake sequence wrong");

	a_sleep_blocked: assert property (
		(pwr_r == CIC_PWR_ON) && wr_cmd && wbyte[CIC_SLEEP_BIT] && reset_cmd |=> !soft_sleep_r
	) else $error("sleep set during soft reset");

	a_code_launch: assert property (
		wr_cmd && code_valid |=> command_code_r == $past(wcode) && command_start_r == ($past(wcode) != CIC_CMD_IDLE)
	) else $error("command code not launched");

	// pin level tracks status and inversion
	a_pin_level: assert property (
		push_pull && $stable(push_pull) |=> int_pin_out_r == $past(irq_status ^ com_en_r[CIC_INVERT_BIT])
	) else $error("interrupt pin level wrong");

	a_open_drain: assert property (
		!push_pull |=> !int_pin_out_r && (int_pin_oe_n_r == $past(int_level))
	) else $error("open drain pin drove high");

	// write with set-select low clears the marked bits
	a_req_clear: assert property (
		wr_en && hit_com_r && !wbyte[CIC_SET_SELECT_BIT] && !(|com_set)
		|=> (com_req & $past(wbyte[6:0])) == 7'h00
	) else $error("request bits not cleared");

	// undefined code reverts to idle with request
	a_bad_code: assert property (
		wr_cmd && !code_valid |=> command_code_r == CIC_CMD_IDLE && com_req[4]
	) else $error("undefined command not reverted");

	// host idle write raises no new idle request
	a_host_idle: assert property (
		wr_cmd && (wcode == CIC_CMD_IDLE) && !com_req[4] && !(wr_en && hit_com_r) |=> !com_req[4]
	) else $error("idle request set by host idle write");

	// high alert request holds while status drops
	a_hi_latch: assert property (
		com_req[3] && !(wr_en && hit_com_r) |=> com_req[3]
	) else $error("high alert request lost");

	// status reaches the pin on the next cycle
	a_status_path: assert property (
		push_pull && !com_en_r[CIC_INVERT_BIT] && irq_status && $stable(com_en_r) && $stable(div_en_r)
		|=> int_pin_out_r
	) else $error("enabled request did not reach pin");
endmodule
`default_nettype wire

// ==== tb/cic_host_pin.sv ====
// Host-side view of the interrupt pin with its pull-up resistor
`default_nettype none
module cic_host_pin (
	// Pin drive from the block
	input  wire logic int_pin_out_r,
	input  wire logic int_pin_oe_n_r,
	// Level seen by the host
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_level = int_pin_oe_n_r ? 1'b1 : int_pin_out_r;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the command and interrupt control block
`default_nettype none
module tb import cic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk;
	logic        nrst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	cic_events_t evs;
	logic        card_serial_input;
	logic [3:0]  command_code_r;
	logic        command_start_r;
	logic        receiver_analog_off_r;
	logic        soft_sleep_r;
	logic        int_pin_out_r;
	logic        int_pin_oe_n_r;
	logic        pin_level;
	logic [31:0] rnd;
	logic [31:0] rd;
	int          bad_count;
	int          n_checks;
	int          starts;
	int          mreg [6];

	cic_command_irq cic_command_irq_i (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev(evs),
		.card_serial_input(card_serial_input), .command_code_r(command_code_r),
		.command_start_r(command_start_r), .receiver_analog_off_r(receiver_analog_off_r),
		.soft_sleep_r(soft_sleep_r), .int_pin_out_r(int_pin_out_r), .int_pin_oe_n_r(int_pin_oe_n_r));
	cic_host_pin cic_host_pin_i (.int_pin_out_r(int_pin_out_r), .int_pin_oe_n_r(int_pin_oe_n_r),
		.pin_level(pin_level));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (command_start_r === 1'b1) begin
			starts <= starts + 1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tally_and_finish();
		$display("TB: checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Avalon request held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
		int k;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= !w;
		avs_write <= w;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// set-select writes kept in the model
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, d, 1'b1);
		case (a)
			8'h08: mreg[2] = d;
			8'h0c: mreg[3] = d & 8'h94;
			8'h10: mreg[4] = d[7] ? (mreg[4] | d[6:0]) : (mreg[4] & ~{25'h0, d[6:0]});
			8'h14: mreg[5] = d[7] ? (mreg[5] | (d & 8'h14)) : (mreg[5] & ~{24'h0, d & 8'h14});
			default: ;
		endcase
	endtask

	task automatic rx(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 8'h00, 1'b0);
		check(rd, exp);
	endtask

	task automatic pulse(input logic [16:0] v);
		@(posedge ref_clk);
		evs <= cic_events_t'(evs | v);
		@(posedge ref_clk);
		evs <= cic_events_t'(evs & ~v);
	endtask

	initial begin
		#800000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		int i;
		logic st;
		logic [16:0] evt [7];
		int bitn [7];
		evt = '{17'h10000, 17'h08000, 17'h01000, 17'h00800, 17'h00001, 17'h00400, 17'h00200};
		bitn = '{6, 5, 3, 2, 1, 0, 2};
		nrst = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		evs = '0;
		card_serial_input = 1'b0;
		bad_count = 0;
		n_checks = 0;
		starts = 0;
		rnd = 32'h0001862e;
		mreg = '{0, 8'h20, 8'h80, 8'h00, 8'h14, 8'h00};
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 1; i < 6; i++) begin
			rx(8'(i * 4), mreg[i]);
		end
		check(32'(pin_level), 32'h1);
		check(32'(int_pin_oe_n_r), 32'h1);
		rx(8'h18, 32'h0);
		wr(8'h09, 8'h00);
		rx(8'h08, mreg[2]);
		wr(8'h10, 8'hff);
		rx(8'h10, mreg[4]);
		wr(8'h10, 8'h7f);
		rx(8'h10, mreg[4]);
		wr(8'h14, 8'hff);
		rx(8'h14, mreg[5]);
		wr(8'h14, 8'h14);
		// Seven hardware events each set their own request and nothing else
		for (i = 0; i < 7; i++) begin
			pulse(evt[i]);
			if (i < 6) mreg[4] |= 1 << bitn[i];
			else mreg[5] |= 1 << bitn[i];
			rx(8'h10, mreg[4]);
			rx(8'h14, mreg[5]);
		end
		card_serial_input <= 1'b1;
		repeat (8) @(posedge ref_clk);
		mreg[5] |= 16;
		rx(8'h14, mreg[5]);
		wr(8'h10, 8'h7f);
		@(posedge ref_clk);
		evs <= cic_events_t'(evs | 17'h02000);
		pulse(17'h08000);
		rx(8'h10, mreg[4]);
		pulse(17'h0c000);
		mreg[4] |= 32;
		rx(8'h10, mreg[4]);
		evs <= '0;
		wr(8'h10, 8'h7f);
		wr(8'h04, 8'h01);
		rx(8'h04, 32'h01);
		check(32'(command_code_r), 32'h1);
		check(32'(starts), 32'h1);
		check(32'(receiver_analog_off_r), 32'h0);
		pulse(17'h00100);
		mreg[4] |= 16;
		rx(8'h04, 32'h00);
		rx(8'h10, mreg[4]);
		wr(8'h10, 8'h7f);
		wr(8'h04, 8'h08);
		mreg[4] |= 16;
		rx(8'h04, 32'h00);
		check(32'(command_code_r), 32'h0);
		rx(8'h10, mreg[4]);
		check(32'(starts), 32'h1);
		wr(8'h10, 8'h7f);
		wr(8'h04, 8'h00);
		rx(8'h10, mreg[4]);
		wr(8'h04, 8'h20);
		@(negedge ref_clk);
		check(32'(receiver_analog_off_r), 32'h1);
		wr(8'h04, 8'h10);
		@(negedge ref_clk);
		check(32'(soft_sleep_r), 32'h1);
		rx(8'h04, 32'h10);
		wr(8'h04, 8'h00);
		@(negedge ref_clk);
		check(32'(soft_sleep_r), 32'h0);
		rx(8'h04, 32'h10);
		repeat (100) @(posedge ref_clk);
		rx(8'h04, 32'h00);
		wr(8'h04, 8'h1f);
		@(negedge ref_clk);
		check(32'(soft_sleep_r), 32'h0);
		rx(8'h04, 32'h0f);
		// Sleep write while the soft reset command runs
		wr(8'h04, 8'h10);
		@(negedge ref_clk);
		check(32'(soft_sleep_r), 32'h0);
		rx(8'h04, 32'h00);
		rx(8'h10, mreg[4]);
		pulse(17'h00100);
		// Random enables and requests against the pin model
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(8'h10, 8'h7f);
			wr(8'h14, 8'h14);
			wr(8'h08, rnd[7:0]);
			wr(8'h0c, rnd[15:8]);
			wr(8'h10, {1'b1, rnd[22:16]});
			wr(8'h14, rnd[31:24] | 8'h80);
			repeat (2) @(posedge ref_clk);
			st = |(mreg[2][6:0] & mreg[4][6:0]) | |(mreg[3][7:0] & mreg[5][7:0] & 8'h14);
			check(32'(pin_level), 32'(st ^ mreg[2][7]));
			check(32'(int_pin_oe_n_r), mreg[3][7] ? 32'h0 : 32'(st ^ mreg[2][7]));
			check(32'(int_pin_out_r), mreg[3][7] ? 32'(st ^ mreg[2][7]) : 32'h0);
			rx(8'h0c, mreg[3]);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
